// file: rtl/usl_lines.sv
// Purpose: smartcard retry, infrared, bus driver and channel test modes
// Assumes: serial engine on clk supplies bits, ticks and character events
// Notes:   register port reads return data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module usl_lines
   import usl_pkg::*;
#(
   parameter int FW = 8
)
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          ce,
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   input  wire logic          rxd_pin,
   output logic               txd_pin,
   output logic               rts_pin,
   input  wire usl_eng_t      eng,
   output logic               eng_rx_bit,
   output logic               eng_tx_en,
   output logic               eng_rx_en,
   output logic               tx_repeat,
   output logic               tx_parity_bit,
   output logic               two_stop,
   output logic               rx_accept,
   output logic               rx_reject
);
   // ----------------------------------------------------------------
   // registers and decode
   // ----------------------------------------------------------------
   logic [DW-1:0] mode_register;
   logic [FW-1:0] infrared_filter_value;
   logic [10:0]   clock_ratio_field;
   logic          retry_flag;
   logic          parity_error_flag;
   logic          nack_flag;
   logic [2:0]    iter_cnt;
   logic [2:0]    rx_nack_cnt;
   logic [4:0]    nack_cnt;
   logic          rxd_s1;
   logic          rxd_s2;
   logic          ir_pulse;
   logic          ir_rx;

   wire [3:0]      line_mode     = mode_register[MODE_LINE_LSB +: 4];
   wire usl_chan_t channel_mode  = usl_chan_t'(mode_register[MODE_CHAN_LSB +: 2]);
   wire [2:0]      max_iter      = mode_register[MODE_ITER_LSB +: 3];
   wire            nack_limit_enable = mode_register[MODE_NLIM];
   wire            nack_inhibit  = mode_register[MODE_NINH];

   wire is_t0     = line_mode == LM_CARD_T0;
   wire is_t1     = line_mode == LM_CARD_T1;
   wire is_card   = is_t0 | is_t1;
   wire is_ir     = line_mode == LM_IR;
   wire is_busdrv = line_mode == LM_BUSDRV;
   wire is_remote = channel_mode == CH_REMOTE;

   wire wr_ctrl  = reg_wr & (reg_addr == ADDR_CTRL);
   wire wr_mode  = reg_wr & (reg_addr == ADDR_MODE);
   wire wr_filt  = reg_wr & (reg_addr == ADDR_FILT);
   wire wr_ratio = reg_wr & (reg_addr == ADDR_RATIO);

   wire clr_retry = wr_ctrl & reg_wdata[CTRL_CLR_RETRY] & is_card;
   wire clr_par   = wr_ctrl & reg_wdata[CTRL_CLR_PAR];
   wire clr_nack  = wr_ctrl & reg_wdata[CTRL_CLR_NACK];

   // ----------------------------------------------------------------
   // transmit repetition
   // ----------------------------------------------------------------
   wire tx_nack_ev   = eng.tx_nack & is_t0 & ~is_remote;
   wire can_repeat   = (max_iter != ITER_ZERO) & (iter_cnt < max_iter);
   wire do_repeat    = tx_nack_ev & can_repeat;
   wire [2:0] iter_inc = iter_cnt + 3'h1;
   wire retry_set_tx = do_repeat & (iter_inc == max_iter);
   wire [2:0] next_iter = eng.tx_ack ? ITER_ZERO :
                          do_repeat  ? iter_inc :
                          tx_nack_ev ? ITER_ZERO : iter_cnt;

   // ----------------------------------------------------------------
   // receive parity and nack limit
   // ----------------------------------------------------------------
   wire rx_ev     = eng.rx_done & is_card & ~is_remote;
   wire par_bad   = usl_parity(eng.rx_data) != eng.rx_par;
   wire limit_hit = nack_limit_enable & (rx_nack_cnt == max_iter);
   wire lim_acc   = is_t0 & par_bad & ~nack_inhibit & limit_hit;
   wire next_acc  = rx_ev & (~par_bad | (is_t0 & nack_inhibit) | lim_acc);
   wire next_rej  = rx_ev & ~next_acc;
   wire send_nack = next_rej & is_t0;
   wire pe_set    = rx_ev & par_bad & ~lim_acc;
   wire ninh_set  = rx_ev & par_bad & is_t0 & nack_inhibit;
   wire retry_set = retry_set_tx | (rx_ev & lim_acc);
   wire [2:0] next_rx_nack = next_acc ? ITER_ZERO :
                             (send_nack && rx_nack_cnt != ITER_FULL) ?
                             rx_nack_cnt + 3'h1 : rx_nack_cnt;
   wire [4:0] next_nack_cnt = send_nack ? BIT_TICKS :
                              (eng.tick && nack_cnt != 5'h00) ? nack_cnt - 5'h01 : nack_cnt;

   // ----------------------------------------------------------------
   // channel routing
   // ----------------------------------------------------------------
   wire tx_line = is_ir ? ir_pulse : (eng.tx_bit & (nack_cnt == 5'h00));
   wire rx_line = is_ir ? ir_rx : rxd_s2;
   logic next_txd;
   logic next_rx;

   always_comb
   begin
      unique case (channel_mode)
         CH_NORMAL:
         begin
            next_txd = tx_line;
            next_rx  = rx_line;
         end
         CH_ECHO:
         begin
            next_txd = rxd_s2;
            next_rx  = rx_line;
         end
         CH_LOCAL:
         begin
            next_txd = 1'b1;
            next_rx  = eng.tx_bit;
         end
         CH_REMOTE:
         begin
            next_txd = rxd_s2;
            next_rx  = 1'b1;
         end
      endcase
   end

   wire [DW-1:0] stat_word = {{(DW-7){1'b0}}, iter_cnt, rts_pin,
                              nack_flag, parity_error_flag, retry_flag};
   wire [DW-1:0] rd_mux =
      (reg_addr == ADDR_MODE)  ? mode_register :
      (reg_addr == ADDR_STAT)  ? stat_word :
      (reg_addr == ADDR_FILT)  ? {{(DW-FW){1'b0}}, infrared_filter_value} :
      (reg_addr == ADDR_RATIO) ? {5'h00, clock_ratio_field} : '0;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mode_register         <= MODE_RST;
         infrared_filter_value <= FW'(FILT_RST);
         clock_ratio_field     <= RATIO_RST;
         reg_rdata             <= '0;
         rxd_s1                <= 1'b1;
         rxd_s2                <= 1'b1;
      end
      else if (ce)
      begin
         if (wr_mode)
            mode_register <= reg_wdata;
         if (wr_filt)
            infrared_filter_value <= reg_wdata[FW-1:0];
         if (wr_ratio)
            clock_ratio_field <= reg_wdata[10:0];
         reg_rdata <= reg_rd ? rd_mux : '0;
         rxd_s1    <= rxd_pin;
         rxd_s2    <= rxd_s1;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         retry_flag        <= 1'b0;
         parity_error_flag <= 1'b0;
         nack_flag         <= 1'b0;
         iter_cnt          <= ITER_ZERO;
         rx_nack_cnt       <= ITER_ZERO;
         nack_cnt          <= 5'h00;
      end
      else if (ce)
      begin
         retry_flag        <= retry_set | (retry_flag & ~clr_retry);
         parity_error_flag <= pe_set | (parity_error_flag & ~clr_par);
         nack_flag         <= ninh_set | (nack_flag & ~clr_nack);
         iter_cnt          <= next_iter;
         rx_nack_cnt       <= next_rx_nack;
         nack_cnt          <= next_nack_cnt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         txd_pin       <= 1'b1;
         rts_pin       <= 1'b0;
         eng_rx_bit    <= 1'b1;
         eng_tx_en     <= 1'b0;
         eng_rx_en     <= 1'b0;
         tx_repeat     <= 1'b0;
         tx_parity_bit <= 1'b0;
         two_stop      <= 1'b0;
         rx_accept     <= 1'b0;
         rx_reject     <= 1'b0;
      end
      else if (ce)
      begin
         txd_pin       <= next_txd;
         rts_pin       <= is_busdrv & ~eng.tx_empty;
         eng_rx_bit    <= next_rx;
         eng_tx_en     <= mode_register[MODE_TXEN] & ~is_remote;
         eng_rx_en     <= mode_register[MODE_RXEN] & ~is_remote;
         tx_repeat     <= do_repeat;
         tx_parity_bit <= usl_parity(eng.tx_data);
         two_stop      <= mode_register[MODE_STOP2] & ~is_t1;
         rx_accept     <= next_acc;
         rx_reject     <= next_rej;
      end
   end

   // ----------------------------------------------------------------
   // infrared path
   // ----------------------------------------------------------------
   usl_irmod u_mod (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .enable    (is_ir),
      .tick      (eng.tick),
      .bit_start (eng.bit_start),
      .bit_val   (eng.tx_bit),
      .pulse     (ir_pulse)
   );

   usl_irdemod #(.FW(FW)) u_demod (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .enable  (is_ir),
      .tick    (eng.tick),
      .rx      (rxd_s2),
      .filt    (infrared_filter_value),
      .rx_out  (ir_rx)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_nack_req;
      ce && send_nack;
   endsequence
   sequence s_nack_line;
      ce && nack_cnt != 5'h00 && channel_mode == CH_NORMAL && !is_ir;
   endsequence

   a_no_iter_zero: assert property (
      (ce && eng.tx_nack && max_iter == ITER_ZERO) |=> !tx_repeat)
      else $error("repeat issued with zero retry limit");
   a_repeat_nack: assert property (
      (ce && tx_nack_ev && iter_cnt < max_iter) |=> (tx_repeat && iter_cnt == $past(iter_inc)))
      else $error("nacked character not repeated");
   a_retry_set: assert property (
      (ce && retry_set_tx) |=> retry_flag)
      else $error("retry flag not set at limit");
   a_ack_clears: assert property (
      (ce && eng.tx_ack) |=> (iter_cnt == ITER_ZERO && !tx_repeat))
      else $error("ack did not clear repeat count");
   a_clear_cmd: assert property (
      (ce && clr_retry && !retry_set) |=> !retry_flag)
      else $error("clear command left retry flag set");
   a_clear_ignored: assert property (
      (ce && wr_ctrl && !is_card && retry_flag) |=> retry_flag)
      else $error("clear command acted outside smartcard mode");
   a_nack_limit: assert property (
      (ce && rx_ev && lim_acc) |=> (rx_accept && retry_flag && nack_cnt == $past(nack_cnt)))
      else $error("nack limit did not accept character");
   a_nack_cap: assert property (
      (ce && rx_ev && is_t0 && par_bad && !nack_inhibit && nack_limit_enable
       && rx_nack_cnt == max_iter) |=> (rx_accept && !rx_reject))
      else $error("receive nack count not capped at limit");
   a_t1_parity: assert property (
      (ce && rx_ev && is_t1 && par_bad) |=> (parity_error_flag && nack_cnt == 5'h00))
      else $error("block protocol parity error not flagged");
   a_t1_one_stop: assert property (
      (ce && is_t1) |=> !two_stop)
      else $error("block protocol framed with two stop bits");
   a_nack_start: assert property (
      s_nack_req |=> (nack_cnt == BIT_TICKS && rx_reject))
      else $error("nack not started on parity error");
   a_nack_drive: assert property (
      s_nack_line |=> !txd_pin)
      else $error("line not low during nack");
   a_busdrv_rts: assert property (
      (ce && is_busdrv) |=> (rts_pin == !$past(eng.tx_empty)))
      else $error("request-to-send not inverse of empty");
   a_normal_path: assert property (
      (ce && channel_mode == CH_NORMAL && !is_ir && nack_cnt == 5'h00)
      |=> (txd_pin == $past(eng.tx_bit) && eng_rx_bit == $past(rxd_s2)))
      else $error("normal routing wrong");
   a_echo_path: assert property (
      (ce && channel_mode == CH_ECHO) |=> (txd_pin == $past(rxd_s2) && eng_rx_bit == $past(rx_line)))
      else $error("echo routing wrong");
   a_local_loop: assert property (
      (ce && channel_mode == CH_LOCAL) |=> (txd_pin && eng_rx_bit == $past(eng.tx_bit)))
      else $error("local loopback routing wrong");
   a_remote_loop: assert property (
      (ce && is_remote) |=> (txd_pin == $past(rxd_s2) && !eng_tx_en && !eng_rx_en))
      else $error("remote loopback routing wrong");
endmodule
`default_nettype wire

// file: rtl/usl_pkg.sv
// Purpose: shared constants and types for the special line mode block
// Assumes: 16-bit register port, 16x oversample tick from the serial engine
// Notes:   register offsets are word indices on the plain register port
package usl_pkg;

   localparam int DW = 16;
   localparam int AW = 4;

   // ----------------------------------------------------------------
   // register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] ADDR_CTRL  = 4'h0;
   localparam logic [AW-1:0] ADDR_MODE  = 4'h1;
   localparam logic [AW-1:0] ADDR_STAT  = 4'h2;
   localparam logic [AW-1:0] ADDR_FILT  = 4'h3;
   localparam logic [AW-1:0] ADDR_RATIO = 4'h4;

   localparam logic [DW-1:0] MODE_RST  = 16'h0000;
   localparam logic [7:0]    FILT_RST  = 8'h00;
   localparam logic [10:0]   RATIO_RST = 11'h174;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MODE_LINE_LSB  = 0;
   localparam int MODE_CHAN_LSB  = 4;
   localparam int MODE_ITER_LSB  = 6;
   localparam int MODE_NLIM      = 9;
   localparam int MODE_NINH      = 10;
   localparam int MODE_RXEN      = 11;
   localparam int MODE_TXEN      = 12;
   localparam int MODE_STOP2     = 13;
   localparam int CTRL_CLR_RETRY = 0;
   localparam int CTRL_CLR_PAR   = 1;
   localparam int CTRL_CLR_NACK  = 2;

   // ----------------------------------------------------------------
   // encodings and timing
   // ----------------------------------------------------------------
   localparam logic [3:0] LM_BUSDRV  = 4'h1;
   localparam logic [3:0] LM_CARD_T0 = 4'h4;
   localparam logic [3:0] LM_CARD_T1 = 4'h6;
   localparam logic [3:0] LM_IR      = 4'h8;

   typedef enum logic [1:0] {
      CH_NORMAL = 2'b00,
      CH_ECHO   = 2'b01,
      CH_LOCAL  = 2'b10,
      CH_REMOTE = 2'b11
   } usl_chan_t;

   localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
   localparam logic [4:0] BIT_TICKS      = 5'h10;
   localparam logic [2:0] ITER_ZERO      = 3'h0;
   localparam logic [2:0] ITER_FULL      = 3'h7;

   // ----------------------------------------------------------------
   // serial engine status and events
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       tx_bit;
      logic       tx_empty;
      logic       tick;
      logic       bit_start;
      logic       tx_nack;
      logic       tx_ack;
      logic       rx_done;
      logic       rx_par;
      logic [7:0] rx_data;
      logic [7:0] tx_data;
   } usl_eng_t;

   function automatic logic usl_parity(input logic [7:0] d);
      return ^d;
   endfunction

endpackage

// file: rtl/usl_irmod.sv
// Purpose: infrared return-to-zero-inverted pulse modulator
// Assumes: tick is the 16x oversample strobe, bit_start marks each bit
// Notes:   pulse is active high, idle low
`timescale 1ns/1ps
`default_nettype none
module usl_irmod
   import usl_pkg::*;
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic enable,
   input  wire logic tick,
   input  wire logic bit_start,
   input  wire logic bit_val,
   output logic      pulse
);
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   wire        load = enable & bit_start & ~bit_val;

   assign next_cnt = load ? IR_PULSE_TICKS :
                     (tick && cnt != 5'h00) ? cnt - 5'h01 : cnt;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt   <= 5'h00;
         pulse <= 1'b0;
      end
      else if (ce)
      begin
         cnt   <= next_cnt;
         pulse <= next_cnt != 5'h00;
      end
   end

   a_zero_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && load) |=> (pulse && cnt == IR_PULSE_TICKS))
      else $error("zero bit did not start a 3/16 pulse");
endmodule
`default_nettype wire

// file: rtl/usl_irdemod.sv
// Purpose: infrared receive pulse filter and demodulator
// Assumes: rx is already synchronised to clk
// Notes:   a pulse shorter than the filter value is dropped as a glitch
`timescale 1ns/1ps
`default_nettype none
module usl_irdemod
   import usl_pkg::*;
#(
   parameter int FW = 8
)
(
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          ce,
   input  wire logic          enable,
   input  wire logic          tick,
   input  wire logic          rx,
   input  wire logic [FW-1:0] filt,
   output logic               rx_out
);
   logic          rx_d;
   logic          run;
   logic [FW-1:0] cnt;
   logic [4:0]    low_cnt;
   logic [4:0]    next_low;
   wire           fall = rx_d & ~rx;
   wire           rise = ~rx_d & rx;
   wire           expire = run & ~rise & (cnt == '0);

   assign next_low = expire ? BIT_TICKS :
                     (tick && low_cnt != 5'h00) ? low_cnt - 5'h01 : low_cnt;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rx_d    <= 1'b1;
         run     <= 1'b0;
         cnt     <= '0;
         low_cnt <= 5'h00;
         rx_out  <= 1'b1;
      end
      else if (ce)
      begin
         rx_d <= rx;
         if (!enable || rise || expire)
         begin
            run <= 1'b0;
            cnt <= filt;
         end
         else if (fall)
         begin
            run <= 1'b1;
            cnt <= filt;
         end
         else if (run)
            cnt <= cnt - 1'b1;
         low_cnt <= enable ? next_low : 5'h00;
         rx_out  <= !enable || next_low == 5'h00;
      end
   end

   a_rise_reload: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && enable && run && rise) |=> (!run && cnt == $past(filt)))
      else $error("rising edge did not stop and reload the filter");
   a_expire_low: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && enable && expire) |=> (!rx_out && low_cnt == BIT_TICKS))
      else $error("filter expiry did not drive receiver low");
endmodule
`default_nettype wire

// file: dv/usl_line_mdl.sv
// Purpose: far-side line model (card, infrared or bus transceiver)
// Assumes: line has a pull-up, so a released line reads high
// Notes:   driven by bench calls just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module usl_line_mdl
(
   input  wire logic clk,
   output logic      rxd_pin
);
   // ---------------------------------------------
   // line drive
   // ---------------------------------------------
   initial rxd_pin = 1'b1;
   task automatic low(input int n);
      rxd_pin <= 1'b0;
      repeat (n) @(posedge clk);
      rxd_pin <= 1'b1;
   endtask
   task automatic put(input logic v);
      rxd_pin <= v;
   endtask
endmodule
`default_nettype wire

// file: dv/usl_lines_tb.sv
// Purpose: self-checking bench for the special line mode block
// Assumes: tick held high, so one bit time is 16 clocks
// Notes:   bench drives the engine struct directly
`timescale 1ns/1ps
`default_nettype none
module usl_lines_tb
   import usl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wd = '0, rdat, d;
   logic rxd, txd, rts, rxb, txe, rxe, rep, tpar, two, acc, rej;
   usl_eng_t eng = '{tx_bit:1'b1, tx_empty:1'b1, tick:1'b1, default:'0};
   int mismatches = 0, n_checks = 0, cyc = 0, c;
   logic [3:0] e;
   always #4 clk = ~clk;
   usl_line_mdl line (.clk(clk), .rxd_pin(rxd));
   usl_lines dut (.clk(clk), .sys_rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .rxd_pin(rxd), .txd_pin(txd),
      .rts_pin(rts), .eng(eng), .eng_rx_bit(rxb), .eng_tx_en(txe), .eng_rx_en(rxe),
      .tx_repeat(rep), .tx_parity_bit(tpar), .two_stop(two), .rx_accept(acc),
      .rx_reject(rej));
   // ---------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------
   task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge clk);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [AW-1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask
   task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] x);
      n_checks++;
      if (g !== x)
      begin
         mismatches++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
   endtask
   // event pulse: {tx_nack, tx_ack, rx_done}; returns with answers settled
   task automatic evt(input logic [2:0] k);
      @(posedge clk);
      {eng.tx_nack, eng.tx_ack, eng.rx_done} <= k;
      @(posedge clk);
      {eng.tx_nack, eng.tx_ack, eng.rx_done} <= 3'h0;
      #1;
   endtask
   task automatic cnt(ref logic s, input logic lv, input int n);
      c = 0;
      repeat (n)
      begin
         @(posedge clk);
         #1 c += int'(s === lv);
      end
   endtask
   task automatic bitgo(input logic v);
      @(posedge clk);
      eng.tx_bit <= v;
      eng.bit_start <= 1'b1;
      @(posedge clk);
      eng.bit_start <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rreg(ADDR_MODE); chk(d, 16'h0000);
      rreg(ADDR_RATIO); chk(d, 16'h0174);
      rreg(ADDR_STAT); chk(d, 16'h0000);
      rreg(4'h7); chk(d, 16'h0000);
      wreg(ADDR_MODE, 16'h0084);
      evt(3'h4); chk(rep, 1'b1);
      rreg(ADDR_STAT); chk(d, 16'h0010);
      evt(3'h4); chk(rep, 1'b1);
      rreg(ADDR_STAT); chk(d, 16'h0021);
      evt(3'h4); chk(rep, 1'b0);
      evt(3'h4); evt(3'h2); rreg(ADDR_STAT); chk(d, 16'h0001);
      wreg(ADDR_MODE, 16'h0000); wreg(ADDR_CTRL, 16'h0001);
      rreg(ADDR_STAT); chk(d, 16'h0001);
      wreg(ADDR_MODE, 16'h0004); wreg(ADDR_CTRL, 16'h0001);
      rreg(ADDR_STAT); chk(d, 16'h0000);
      evt(3'h4); chk(rep, 1'b0);
      @(posedge clk) eng.rx_data <= 8'h01;
      evt(3'h1); chk(rej, 1'b1);
      cnt(txd, 1'b0, 24); chk(16'(c), 16'h0010);
      wreg(ADDR_CTRL, 16'h0006); wreg(ADDR_MODE, 16'h0404);
      evt(3'h1); chk(acc, 1'b1);
      cnt(txd, 1'b0, 24); chk(16'(c), 16'h0000);
      wreg(ADDR_CTRL, 16'h0006); wreg(ADDR_MODE, 16'h0244);
      evt(3'h1); chk(rej, 1'b1);
      cnt(txd, 1'b0, 24);
      evt(3'h1); chk(acc, 1'b1);
      cnt(txd, 1'b0, 24); chk(16'(c), 16'h0000);
      rreg(ADDR_STAT); chk(d, 16'h0003);
      wreg(ADDR_CTRL, 16'h0007); wreg(ADDR_MODE, 16'h2006);
      eng.tx_data <= 8'h07;
      evt(3'h1); chk({two, tpar, rej}, 3'b011);
      cnt(txd, 1'b0, 24); chk(16'(c), 16'h0000);
      rreg(ADDR_STAT); chk(d, 16'h0002);
      @(posedge clk) eng.rx_par <= 1'b1;
      evt(3'h1); chk(acc, 1'b1);
      wreg(ADDR_MODE, 16'h0001);
      eng.tx_empty <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(rts, 1'b1);
      @(posedge clk) eng.tx_empty <= 1'b1;
      @(posedge clk);
      #1 chk(rts, 1'b0);
      for (int ch = 0; ch < 4; ch++)
         for (int v = 0; v < 2; v++)
         begin
            wreg(ADDR_MODE, 16'h1800 | 16'(ch << 4));
            line.put(v[0]);
            eng.tx_bit <= ~v[0];
            repeat (5) @(posedge clk);
            e[3:2] = (ch == 3) ? 2'b00 : 2'b11;
            e[1:0] = (ch == 0) ? {~v[0], v[0]} : (ch == 1) ? {v[0], v[0]} :
                     (ch == 2) ? {1'b1, ~v[0]} : {v[0], 1'b1};
            #1 chk({txe, rxe, txd, rxb}, e);
         end
      line.put(1'b1);
      wreg(ADDR_RATIO, 16'h0001);
      wreg(ADDR_FILT, 16'h0004);
      wreg(ADDR_MODE, 16'h1008);
      fork bitgo(1'b0); cnt(txd, 1'b1, 20); join
      chk(16'(c), 16'h0003);
      fork bitgo(1'b1); cnt(txd, 1'b1, 20); join
      chk(16'(c), 16'h0000);
      wreg(ADDR_MODE, 16'h0808);
      fork line.low(2); cnt(rxb, 1'b0, 30); join
      chk(16'(c), 16'h0000);
      fork line.low(12); cnt(rxb, 1'b0, 40); join
      chk(16'(c), 16'h0010);
      report_and_stop();
   end
endmodule
`default_nettype wire
